// [design/dtrc_defs.svh]
// register offsets, field positions and request codes of the dma request control
`ifndef DTRC_DEFS_SVH
`define DTRC_DEFS_SVH
`define DTRC_NCH 6
`define DTRC_NCH_A 4'h6
`define DTRC_CW 24
`define DTRC_A_CTRL 4'h0
`define DTRC_A_CNT 4'h4
`define DTRC_A_SEL 4'h8
`define DTRC_A_OPER 8'h60
`define DTRC_B_DE 0
`define DTRC_B_TE 1
`define DTRC_B_IE 2
`define DTRC_B_TS 3
`define DTRC_B_RS 5
`define DTRC_B_DL 9
`define DTRC_B_DS 10
`define DTRC_B_DO 11
`define DTRC_B_ME 0
`define DTRC_B_NMI 1
`define DTRC_B_AE 2
`define DTRC_B_PR 3
`define DTRC_RS_DUAL 4'h0
`define DTRC_RS_SWR 4'h2
`define DTRC_RS_SRD 4'h3
`define DTRC_RS_AUTO 4'h4
`define DTRC_RS_PERI 4'h8
`define DTRC_MID_U0 6'h08
`define DTRC_MID_U1 6'h0A
`define DTRC_MID_S0 6'h14
`define DTRC_MID_S1 6'h15
`define DTRC_RID_TX 2'h1
`define DTRC_RID_RX 2'h2
`define DTRC_PR_FIX1 2'h0
`define DTRC_PR_FIX2 2'h1
`define DTRC_FIX2_ORD 18'h2C2D0
`define DTRC_CNT_LAST 24'h000001
`endif

// [design/dtrc_pkg.sv]
// types shared by the dma request control
package dtrc_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_MOVE = 2'b10
	} dtrc_state_e;
	typedef logic [2:0] dtrc_ch_t;
endpackage : dtrc_pkg

// [design/dtrc_top.sv]
// dma request control: channel registers, request sensing, arbiter, sequencer
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "dtrc_defs.svh"
// Notes on behaviour
// - transfer needs both enables, all flags clear
// - one transfer unit per accepted request
// - auto mode requests internally once enabled
// - count drops by one per unit
// - count reaching zero ends, interrupts if enabled
// - address error or nmi aborts transfers
// - clearing channel or master enable aborts
// - select field plus selector picks source
// - external pins request transfers while enabled
// - codes 0000 dual, 0010/0011 single address
// - polarity and edge bits pick detection
// - pin ignored from accept until acknowledge
// - overrun-0 does transfers equal to requests
// - overrun-1 does one extra transfer
// - overrun bit picks overrun-0 or overrun-1
// - select 1000 takes serial unit requests
// - module and register ids pick unit, cycle steal
// - pending channels start in priority order
// - requester need not be source or destination
// - selector honoured only with select 1000
// - fixed ascending order, fixed table order or round robin
module dtrc_top (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic ext_request_in0_i,
	input wire logic ext_request_in1_i,
	input wire logic [3:0] tx_empty_request_i,
	input wire logic [3:0] rx_full_request_i,
	input wire logic nmi_i,
	input wire logic addr_error_i,
	input wire logic xfer_done_i,
	output logic xfer_req_o,
	output logic [2:0] xfer_ch_o,
	output logic [1:0] xfer_size_o,
	output logic xfer_single_o,
	output logic xfer_to_dev_o,
	output logic xfer_steal_o,
	output logic xfer_abort_o,
	output logic [1:0] transfer_acknowledge_out_o,
	output logic transfer_end_interrupt_o
);
	logic [5:0] de, te, ie, dl, ds, dov;
	logic [1:0] ts [6];
	logic [3:0] rs [6];
	logic [7:0] sel [6];
	logic [`DTRC_CW-1:0] cnt [6];
	logic [31:0] ctl_rd [6];
	logic me, nmi_flag, aef;
	logic [1:0] pr;
	logic [5:0] en, req, blk, grd, pend, smp, xm, sgl, tod, stl, pins;
	dtrc_pkg::dtrc_state_e st;
	dtrc_pkg::dtrc_ch_t cur, gch, rr_top;
	logic gok, done, leave;
	logic [3:0] ach, aoff;
	logic [17:0] fix2;

	assign ach = reg_addr_i[7:4];
	assign aoff = reg_addr_i[3:0];
	assign pins = {4'h0, ext_request_in1_i, ext_request_in0_i};
	assign fix2 = `DTRC_FIX2_ORD;
	assign done = st == dtrc_pkg::ST_MOVE && xfer_done_i && en[cur];
	assign leave = st == dtrc_pkg::ST_MOVE && (xfer_done_i || !en[cur]);

	// ---------------------------------------------------------------
	// per-channel registers and request sensing
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `DTRC_NCH; gi++) begin : g_ch
			logic wr_ctl, wr_cnt, wr_sel, ev_done, acc;
			logic pin, lvl, edg, isx, sns, uok, preq;
			logic [1:0] u;
			assign wr_ctl = reg_wr_i && ach == 4'(gi) &&
				aoff == `DTRC_A_CTRL;
			assign wr_cnt = reg_wr_i && ach == 4'(gi) &&
				aoff == `DTRC_A_CNT;
			assign wr_sel = reg_wr_i && ach == 4'(gi) &&
				aoff == `DTRC_A_SEL;
			assign ev_done = done && cur == 3'(gi);
			assign acc = st == dtrc_pkg::ST_IDLE && gok && gch == 3'(gi);
			assign en[gi] = de[gi] && me && !te[gi] && !aef && !nmi_flag;
			assign ctl_rd[gi] = {20'h0, dov[gi], ds[gi], dl[gi], rs[gi],
				ts[gi], ie[gi], te[gi], de[gi]};

			always_ff @(posedge clk_sys_i) begin : ctl
				if (!rstn_i) begin
					de[gi] <= 1'b0;
					ie[gi] <= 1'b0;
					ts[gi] <= 2'h0;
					rs[gi] <= 4'h0;
					dl[gi] <= 1'b0;
					ds[gi] <= 1'b0;
					dov[gi] <= 1'b0;
				end else if (wr_ctl) begin
					de[gi] <= reg_wdata_i[`DTRC_B_DE];
					ie[gi] <= reg_wdata_i[`DTRC_B_IE];
					ts[gi] <= reg_wdata_i[`DTRC_B_TS +: 2];
					rs[gi] <= reg_wdata_i[`DTRC_B_RS +: 4];
					dl[gi] <= reg_wdata_i[`DTRC_B_DL];
					ds[gi] <= reg_wdata_i[`DTRC_B_DS];
					dov[gi] <= reg_wdata_i[`DTRC_B_DO];
				end
			end

			// set wins over a clearing write in the same cycle
			always_ff @(posedge clk_sys_i) begin : endf
				if (!rstn_i)
					te[gi] <= 1'b0;
				else if (ev_done && cnt[gi] == `DTRC_CNT_LAST)
					te[gi] <= 1'b1;
				else if (wr_ctl && !reg_wdata_i[`DTRC_B_TE])
					te[gi] <= 1'b0;
			end

			always_ff @(posedge clk_sys_i) begin : count
				if (!rstn_i)
					cnt[gi] <= '0;
				else if (wr_cnt)
					cnt[gi] <= reg_wdata_i[`DTRC_CW-1:0];
				else if (ev_done)
					cnt[gi] <= cnt[gi] - 1'b1;
			end

			always_ff @(posedge clk_sys_i) begin : selr
				if (!rstn_i)
					sel[gi] <= 8'h00;
				else if (wr_sel)
					sel[gi] <= reg_wdata_i[7:0];
			end

			// external pins exist on channels 0 and 1 only
			assign pin = pins[gi];
			assign isx = (gi < 2) && (rs[gi] == `DTRC_RS_DUAL ||
				rs[gi] == `DTRC_RS_SWR || rs[gi] == `DTRC_RS_SRD);
			assign lvl = dl[gi] ? pin : !pin;
			assign edg = dl[gi] ? (pin && !smp[gi]) : (!pin && smp[gi]);
			assign sns = !blk[gi] && !grd[gi];
			assign xm[gi] = isx;
			assign sgl[gi] = rs[gi] == `DTRC_RS_SWR ||
				rs[gi] == `DTRC_RS_SRD;
			assign tod[gi] = rs[gi] == `DTRC_RS_SWR;
			assign stl[gi] = rs[gi] == `DTRC_RS_PERI;

			always_comb begin
				u = 2'h0;
				uok = 1'b1;
				case (sel[gi][7:2])
					`DTRC_MID_U0: u = 2'h0;
					`DTRC_MID_U1: u = 2'h1;
					`DTRC_MID_S0: u = 2'h2;
					`DTRC_MID_S1: u = 2'h3;
					default: uok = 1'b0;
				endcase
				preq = 1'b0;
				if (uok && rs[gi] == `DTRC_RS_PERI) begin
					if (sel[gi][1:0] == `DTRC_RID_TX)
						preq = tx_empty_request_i[u];
					else if (sel[gi][1:0] == `DTRC_RID_RX)
						preq = rx_full_request_i[u];
				end
			end

			always_ff @(posedge clk_sys_i) begin : samp
				if (!rstn_i)
					smp[gi] <= 1'b0;
				else
					smp[gi] <= pin;
			end

			// an edge is held until granted; edges while blind are lost
			always_ff @(posedge clk_sys_i) begin : edgl
				if (!rstn_i)
					pend[gi] <= 1'b0;
				else if (acc || !isx || !ds[gi])
					pend[gi] <= 1'b0;
				else if (sns && edg)
					pend[gi] <= 1'b1;
			end

			always_ff @(posedge clk_sys_i) begin : blind
				if (!rstn_i)
					blk[gi] <= 1'b0;
				else if (acc)
					blk[gi] <= 1'b1;
				else if (leave && cur == 3'(gi))
					blk[gi] <= 1'b0;
			end

			// overrun-0 keeps the pin blind through the acknowledge
			// cycle so a level still active is not counted again
			always_ff @(posedge clk_sys_i) begin : guard
				if (!rstn_i)
					grd[gi] <= 1'b0;
				else
					grd[gi] <= ev_done && isx && !ds[gi] &&
						!dov[gi];
			end

			assign req[gi] = en[gi] && (
				rs[gi] == `DTRC_RS_AUTO ||
				(isx && (ds[gi] ? pend[gi] : (lvl && sns))) ||
				(preq && sns));
		end
	endgenerate

	// ---------------------------------------------------------------
	// operation register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin : oper
		if (!rstn_i) begin
			me <= 1'b0;
			pr <= `DTRC_PR_FIX1;
		end else if (reg_wr_i && reg_addr_i == `DTRC_A_OPER) begin
			me <= reg_wdata_i[`DTRC_B_ME];
			pr <= reg_wdata_i[`DTRC_B_PR +: 2];
		end
	end

	always_ff @(posedge clk_sys_i) begin : flags
		if (!rstn_i) begin
			nmi_flag <= 1'b0;
			aef <= 1'b0;
		end else begin
			if (nmi_i)
				nmi_flag <= 1'b1;
			else if (reg_wr_i && reg_addr_i == `DTRC_A_OPER &&
				!reg_wdata_i[`DTRC_B_NMI])
				nmi_flag <= 1'b0;
			if (addr_error_i)
				aef <= 1'b1;
			else if (reg_wr_i && reg_addr_i == `DTRC_A_OPER &&
				!reg_wdata_i[`DTRC_B_AE])
				aef <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// arbiter
	// ---------------------------------------------------------------
	// lowest position wins, so the loop walks from the top down
	always_comb begin
		logic [3:0] sum;
		dtrc_pkg::dtrc_ch_t idx;
		sum = 4'h0;
		idx = 3'h0;
		gok = 1'b0;
		gch = 3'h0;
		for (int k = `DTRC_NCH - 1; k >= 0; k--) begin
			sum = {1'b0, rr_top} + 4'(k);
			if (pr == `DTRC_PR_FIX1)
				idx = 3'(k);
			else if (pr == `DTRC_PR_FIX2)
				idx = fix2[3 * k +: 3];
			else if (sum >= `DTRC_NCH_A)
				idx = 3'(sum - `DTRC_NCH_A);
			else
				idx = sum[2:0];
			if (req[idx]) begin
				gok = 1'b1;
				gch = idx;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin : rrobin
		if (!rstn_i)
			rr_top <= 3'h0;
		else if (done && pr[1])
			rr_top <= (cur == 3'(`DTRC_NCH - 1)) ? 3'h0 : cur + 3'h1;
	end

	// ---------------------------------------------------------------
	// unit sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin : seq
		if (!rstn_i) begin
			st <= dtrc_pkg::ST_IDLE;
			cur <= 3'h0;
			xfer_req_o <= 1'b0;
			xfer_ch_o <= 3'h0;
			xfer_size_o <= 2'h0;
			xfer_single_o <= 1'b0;
			xfer_to_dev_o <= 1'b0;
			xfer_steal_o <= 1'b0;
			xfer_abort_o <= 1'b0;
			transfer_acknowledge_out_o <= 2'h0;
		end else begin
			xfer_abort_o <= 1'b0;
			transfer_acknowledge_out_o <= 2'h0;
			unique case (st)
				dtrc_pkg::ST_IDLE: begin
					if (gok) begin
						st <= dtrc_pkg::ST_MOVE;
						cur <= gch;
						xfer_req_o <= 1'b1;
						xfer_ch_o <= gch;
						xfer_size_o <= ts[gch];
						xfer_single_o <= sgl[gch];
						xfer_to_dev_o <= tod[gch];
						xfer_steal_o <= stl[gch];
					end
				end
				dtrc_pkg::ST_MOVE: begin
					if (!en[cur]) begin
						st <= dtrc_pkg::ST_IDLE;
						xfer_req_o <= 1'b0;
						xfer_abort_o <= 1'b1;
					end else if (xfer_done_i) begin
						st <= dtrc_pkg::ST_IDLE;
						xfer_req_o <= 1'b0;
						if (xm[cur])
							transfer_acknowledge_out_o[cur[0]] <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin : irq
		if (!rstn_i)
			transfer_end_interrupt_o <= 1'b0;
		else
			transfer_end_interrupt_o <= |(te & ie);
	end

	// ---------------------------------------------------------------
	// register read port
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin : rdp
		if (!rstn_i)
			reg_rdata_o <= 32'h0;
		else begin
			reg_rdata_o <= 32'h0;
			if (reg_rd_i && reg_addr_i == `DTRC_A_OPER)
				reg_rdata_o <= {27'h0, pr, aef, nmi_flag, me};
			else if (reg_rd_i && ach < `DTRC_NCH_A) begin
				if (aoff == `DTRC_A_CTRL)
					reg_rdata_o <= ctl_rd[ach[2:0]];
				else if (aoff == `DTRC_A_CNT)
					reg_rdata_o <= {8'h0, cnt[ach[2:0]]};
				else if (aoff == `DTRC_A_SEL)
					reg_rdata_o <= {24'h0, sel[ach[2:0]]};
			end
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	sequence s_unit_go;
		st == dtrc_pkg::ST_IDLE && gok;
	endsequence
	sequence s_unit_end;
		done;
	endsequence

	property p_grant_ok;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		s_unit_go |-> en[gch];
	endproperty
	a_grant_ok: assert property (p_grant_ok)
		else $error("grant to a disabled channel");

	property p_unit_req;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		s_unit_go |=> xfer_req_o && xfer_ch_o == $past(gch);
	endproperty
	a_unit_req: assert property (p_unit_req)
		else $error("unit request not raised for grant");

	property p_dec;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		s_unit_end ##0 !reg_wr_i |=>
			cnt[$past(cur)] == $past(cnt[cur]) - 1'b1;
	endproperty
	a_dec: assert property (p_dec)
		else $error("count not decremented");

	property p_end;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		s_unit_end ##0 cnt[cur] == `DTRC_CNT_LAST |=>
			te[$past(cur)] ##1 !req[$past(cur, 2)];
	endproperty
	a_end: assert property (p_end)
		else $error("end flag missing or channel still requests");

	property p_irq;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		|(te & ie) |=> transfer_end_interrupt_o;
	endproperty
	a_irq: assert property (p_irq)
		else $error("end interrupt not raised");

	property p_abort;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		st == dtrc_pkg::ST_MOVE && !en[cur] |=>
			!xfer_req_o && xfer_abort_o ##1 !xfer_abort_o;
	endproperty
	a_abort: assert property (p_abort)
		else $error("disabled transfer not aborted");

	property p_nmi;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		nmi_i |=> nmi_flag && !gok;
	endproperty
	a_nmi: assert property (p_nmi)
		else $error("nmi did not stop transfers");

	property p_ack;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		s_unit_end ##0 xm[cur] |=>
			transfer_acknowledge_out_o[$past(cur[0])] &&
			!blk[$past(cur)];
	endproperty
	a_ack: assert property (p_ack)
		else $error("acknowledge or resensing missing");

	property p_rr;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		s_unit_end ##0 pr[1] |=> ($past(cur) == 3'h5) ?
			rr_top == 3'h0 : rr_top == $past(cur) + 3'h1;
	endproperty
	a_rr: assert property (p_rr)
		else $error("round robin did not rotate");

	property p_peri_gate;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		rs[2] != `DTRC_RS_PERI && rs[2] != `DTRC_RS_AUTO |-> !req[2];
	endproperty
	a_peri_gate: assert property (p_peri_gate)
		else $error("selector honoured without select 1000");
endmodule : dtrc_top

// [tb/dtrc_far.sv]
// far side model: requesting pins, serial units, bus side
`timescale 1ns/1ns
module dtrc_far (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic req_i,
	input wire logic [1:0] ack_i,
	input wire logic [7:0] dly_i,
	output logic done_o,
	output logic [1:0] pin_o,
	output logic [3:0] tx_o,
	output logic [3:0] rx_o
);
	logic [7:0] cnt = 8'h00;
	initial done_o = 1'b0;
	initial pin_o = 2'h1;
	initial tx_o = 4'h0;
	initial rx_o = 4'h0;
	// slow answers keep the pin blind longer
	always @(posedge clk_i) begin
		if (!rstn_i || done_o || !req_i) begin
			done_o <= 1'b0;
			cnt <= 8'h00;
		end else if (cnt == dly_i) begin
			done_o <= 1'b1;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
	task edge_on(input int p, input logic lvl);
		pin_o[p] <= ~lvl;
		repeat (8) @(posedge clk_i);
		pin_o[p] <= lvl;
		repeat (8) @(posedge clk_i);
	endtask : edge_on
	// level held through the acknowledge cycle, dropped after it
	task level_to_ack(input int p, input logic lvl);
		pin_o[p] <= lvl;
		do @(negedge clk_i); while (ack_i[p] !== 1'b1);
		@(posedge clk_i);
		pin_o[p] <= ~lvl;
	endtask : level_to_ack
	task set_ser(input logic [3:0] t, input logic [3:0] r);
		tx_o <= t;
		rx_o <= r;
	endtask : set_ser
endmodule : dtrc_far

// [tb/dtrc_top_tb.sv]
// self-checking bench of the dma request control
`timescale 1ns/1ns
`include "dtrc_defs.svh"
module dtrc_top_tb;
	typedef struct {int c; int s; int ie; int n;} dtrc_ar_s;
	typedef struct {int a; int b; int pr; logic [15:0] q;} dtrc_pr_s;
	typedef struct {int c; logic [3:0] rs; logic [1:0] lv; int dv;
		int n; logic [2:0] f;} dtrc_xr_s;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic nmi = 1'b0;
	logic ae = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] dly = 8'h02;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdo, v;
	logic req, sg, td, st, ab, irq, done;
	logic [2:0] ch, lfl;
	logic [1:0] sz, ack, pin, lsz;
	logic [3:0] tx, rx;
	logic [15:0] seq;
	logic [5:0] mid [4] = '{`DTRC_MID_U0, `DTRC_MID_U1,
		`DTRC_MID_S0, `DTRC_MID_S1};
	int failures = 0;
	int comparisons = 0;
	int units [6] = '{default: 0};
	int acks [2] = '{default: 0};
	int aborts = 0;
	int b, a;
	dtrc_ar_s ar [4] = '{'{0, 0, 1, 1}, '{2, 1, 0, 2}, '{4, 2, 1, 3},
		'{5, 3, 0, 2}};
	dtrc_pr_s pt [3] = '{'{3, 1, 0, 16'h1133}, '{1, 2, 1, 16'h2211},
		'{0, 1, 2, 16'h0101}};
	dtrc_xr_s xt [5] = '{'{1, `DTRC_RS_SWR, 2'h3, 0, 3, 3'h3},
		'{1, `DTRC_RS_SRD, 2'h1, 0, 2, 3'h2},
		'{1, `DTRC_RS_DUAL, 2'h2, 0, 1, 3'h0},
		'{0, `DTRC_RS_DUAL, 2'h0, 0, 1, 3'h0},
		'{0, `DTRC_RS_DUAL, 2'h0, 1, 2, 3'h0}};
	always #20 clk = ~clk;
	dtrc_top i_dut (
		.clk_sys_i(clk),
		.rstn_i(rstn),
		.reg_addr_i(addr),
		.reg_wdata_i(wd),
		.reg_wr_i(wr),
		.reg_rd_i(rd),
		.reg_rdata_o(rdo),
		.ext_request_in0_i(pin[0]),
		.ext_request_in1_i(pin[1]),
		.tx_empty_request_i(tx),
		.rx_full_request_i(rx),
		.nmi_i(nmi),
		.addr_error_i(ae),
		.xfer_done_i(done),
		.xfer_req_o(req),
		.xfer_ch_o(ch),
		.xfer_size_o(sz),
		.xfer_single_o(sg),
		.xfer_to_dev_o(td),
		.xfer_steal_o(st),
		.xfer_abort_o(ab),
		.transfer_acknowledge_out_o(ack),
		.transfer_end_interrupt_o(irq)
	);
	dtrc_far i_far (
		.clk_i(clk),
		.rstn_i(rstn),
		.req_i(req),
		.ack_i(ack),
		.dly_i(dly),
		.done_o(done),
		.pin_o(pin),
		.tx_o(tx),
		.rx_o(rx)
	);
	// ------
	// monitor and helpers
	// ------
	always @(posedge clk) begin
		if (req === 1'b1 && done === 1'b1) begin
			units[ch] <= units[ch] + 1;
			lsz <= sz;
			lfl <= {st, sg, td};
			seq <= {seq[11:0], 1'b0, ch};
		end
		if (ab === 1'b1) aborts <= aborts + 1;
		for (int i = 0; i < 2; i++) if (ack[i] === 1'b1) acks[i] <= acks[i] + 1;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task wreg(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		addr <= ad;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task rreg(input logic [7:0] ad);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdo;
	endtask : rreg
	function logic [7:0] ca(input int c, input logic [7:0] o);
		return 8'(c * 16) + o;
	endfunction : ca
	function logic [31:0] ctl(input int ie, input int s, input logic [3:0] rs,
		input logic [1:0] lv, input int dv);
		return 32'h1 | (32'(ie) << `DTRC_B_IE) | (32'(s) << `DTRC_B_TS) |
			(32'(rs) << `DTRC_B_RS) | (32'(lv[1]) << `DTRC_B_DL) |
			(32'(lv[0]) << `DTRC_B_DS) | (32'(dv) << `DTRC_B_DO);
	endfunction : ctl
	// extra cycles catch a unit too many
	task wait_u(input int c, input int n);
		for (int i = 0; i < 900 && units[c] < n; i++) @(posedge clk);
		repeat (12) @(posedge clk);
	endtask : wait_u
	task conclude;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial begin
		#2000000;
		failures++;
		conclude();
	end
	// ------
	// tests
	// ------
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		foreach (mid[i]) begin
			rreg(i == 1 ? `DTRC_A_OPER : 8'(i * 4));
			chk("reset read", 32'h0, v);
		end
		$display("test reset done");
		for (int r = 0; r < 4; r++) begin
			b = units[ar[r].c];
			wreg(ca(ar[r].c, `DTRC_A_CNT), 32'(ar[r].n));
			wreg(ca(ar[r].c, `DTRC_A_CTRL), ctl(ar[r].ie, ar[r].s,
				`DTRC_RS_AUTO, 2'h0, 0));
			if (r == 0) wreg(`DTRC_A_OPER, 32'h1);
			wait_u(ar[r].c, b + ar[r].n);
			chk("units", b + ar[r].n, units[ar[r].c]);
			chk("size", ar[r].s, lsz);
			rreg(ca(ar[r].c, `DTRC_A_CNT));
			chk("count", 32'h0, v);
			rreg(ca(ar[r].c, `DTRC_A_CTRL));
			chk("end flag", 32'h1, v[`DTRC_B_TE]);
			chk("irq", ar[r].ie, irq);
			wreg(ca(ar[r].c, `DTRC_A_CTRL), 32'h0);
		end
		$display("test auto done");
		foreach (pt[r]) begin
			wreg(`DTRC_A_OPER, 32'h0);
			b = units[pt[r].a];
			a = units[pt[r].b];
			wreg(ca(pt[r].a, `DTRC_A_CNT), 32'h2);
			wreg(ca(pt[r].b, `DTRC_A_CNT), 32'h2);
			wreg(ca(pt[r].a, `DTRC_A_CTRL), ctl(0, 0, `DTRC_RS_AUTO, 2'h0, 0));
			wreg(ca(pt[r].b, `DTRC_A_CTRL), ctl(0, 0, `DTRC_RS_AUTO, 2'h0, 0));
			repeat (10) @(posedge clk);
			chk("held", b, units[pt[r].a]);
			wreg(`DTRC_A_OPER, 32'h1 | (32'(pt[r].pr) << `DTRC_B_PR));
			wait_u(pt[r].a, b + 2);
			wait_u(pt[r].b, a + 2);
			chk("order", pt[r].q, seq);
			wreg(ca(pt[r].a, `DTRC_A_CTRL), 32'h0);
			wreg(ca(pt[r].b, `DTRC_A_CTRL), 32'h0);
		end
		wreg(`DTRC_A_OPER, 32'h1);
		$display("test priority done");
		for (int u = 0; u < 8; u++) begin
			b = units[2];
			i_far.set_ser(u[0] ? ~4'h0 : ~(4'h1 << u[2:1]),
				u[0] ? ~(4'h1 << u[2:1]) : ~4'h0);
			// source or destination aimed at the unit data register
			wreg(ca(2, `DTRC_A_SEL), {24'h0, mid[u[2:1]], u[0] ?
				`DTRC_RID_RX : `DTRC_RID_TX});
			wreg(ca(2, `DTRC_A_CNT), 32'h1);
			wreg(ca(2, `DTRC_A_CTRL), ctl(0, 0, u == 7 ? `DTRC_RS_AUTO + 4'h1 :
				`DTRC_RS_PERI, 2'h0, 0));
			wait_u(2, b);
			chk("other unit", b, units[2]);
			i_far.set_ser(u[0] ? 4'h0 : 4'hF, u[0] ? 4'hF : 4'h0);
			wait_u(2, b + 1);
			chk("unit", b + (u == 7 ? 0 : 1), units[2]);
			if (u == 0) chk("steal", 3'h4, lfl);
			wreg(ca(2, `DTRC_A_CTRL), 32'h0);
		end
		// receive residue is drained by software once the unit is idle
		i_far.set_ser(4'h0, 4'h0);
		$display("test peripheral done");
		foreach (xt[r]) begin
			b = units[xt[r].c];
			a = acks[xt[r].c];
			wreg(ca(xt[r].c, `DTRC_A_CNT), 32'h10);
			wreg(ca(xt[r].c, `DTRC_A_CTRL), ctl(0, 0, xt[r].rs, xt[r].lv,
				xt[r].dv));
			if (xt[r].lv[0]) repeat (xt[r].n) i_far.edge_on(xt[r].c, xt[r].lv[1]);
			else i_far.level_to_ack(xt[r].c, xt[r].lv[1]);
			wait_u(xt[r].c, b + xt[r].n);
			chk("ext units", b + xt[r].n, units[xt[r].c]);
			chk("acks", a + xt[r].n, acks[xt[r].c]);
			chk("mode", xt[r].f, lfl);
			if (r == 0) begin
				dly <= 8'h40;
				repeat (2) i_far.edge_on(1, 1'b1);
				wait_u(1, b + 4);
				chk("blind", b + 4, units[1]);
				dly <= 8'h02;
			end
			wreg(ca(xt[r].c, `DTRC_A_CTRL), 32'h0);
		end
		$display("test external done");
		dly <= 8'h3C;
		b = units[4];
		wreg(ca(4, `DTRC_A_CNT), 32'h5);
		for (int k = 0; k < 4; k++) begin
			a = aborts;
			wreg(`DTRC_A_OPER, 32'h1);
			wreg(ca(4, `DTRC_A_CTRL), ctl(0, 0, `DTRC_RS_AUTO, 2'h0, 0));
			for (int i = 0; i < 50 && req !== 1'b1; i++) @(negedge clk);
			if (k == 0) wreg(ca(4, `DTRC_A_CTRL), 32'h0);
			if (k == 1) wreg(`DTRC_A_OPER, 32'h0);
			@(posedge clk);
			nmi <= k == 2;
			ae <= k == 3;
			@(posedge clk);
			nmi <= 1'b0;
			ae <= 1'b0;
			repeat (4) @(posedge clk);
			chk("dropped", 32'h0, req);
			chk("abort", a + 1, aborts);
			rreg(`DTRC_A_OPER);
			if (k > 1) chk("flag", 32'h1, v[k - 1]);
			wait_u(4, b + 1);
			chk("blocked", b, units[4]);
		end
		rreg(ca(4, `DTRC_A_CNT));
		chk("kept count", 32'h5, v);
		$display("test abort done");
		conclude();
	end
endmodule : dtrc_top_tb
